// ===== pkg/tcs_pkg.sv
// Package for the timer count clock selector: codes, divider taps, register map
package tcs_pkg;
  localparam int unsigned NUM_CHAN      = 6;
  localparam int unsigned SEL_W         = 3;
  localparam int unsigned EDGE_W        = 2;
  localparam int unsigned DIV_W         = 12;
  localparam int unsigned ADDR_W        = 4;
  localparam int unsigned DATA_W        = 8;

  // Prescaler codes
  localparam logic [2:0] SEL_DIV1  = 3'h0;
  localparam logic [2:0] SEL_DIV4  = 3'h1;
  localparam logic [2:0] SEL_DIV16 = 3'h2;
  localparam logic [2:0] SEL_DIV64 = 3'h3;
  localparam logic [2:0] SEL_C4    = 3'h4;
  localparam logic [2:0] SEL_C5    = 3'h5;
  localparam logic [2:0] SEL_C6    = 3'h6;
  localparam logic [2:0] SEL_C7    = 3'h7;

  // Edge field codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  // Divider taps: prescaler bit whose rising edge marks one period
  localparam int unsigned TAP_DIV4    = 1;
  localparam int unsigned TAP_DIV16   = 3;
  localparam int unsigned TAP_DIV64   = 5;
  localparam int unsigned TAP_DIV256  = 7;
  localparam int unsigned TAP_DIV1024 = 9;
  localparam int unsigned TAP_DIV4096 = 11;

  // Control register layout: [4:3] edge select, [2:0] prescaler select
  localparam int unsigned SEL_LSB       = 0;
  localparam int unsigned EDGE_LSB      = 3;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_WR_MASK  = 8'h1f;
  // Mode register: bit 2 set means phase counting
  localparam int unsigned PHASE_BIT     = 2;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [7:0]  MODE_WR_MASK  = 8'h07;

  // Offsets: control of channel n at n, mode of channel n at MODE_BASE + n
  localparam logic [3:0]  CTRL_BASE     = 4'h0;
  localparam logic [3:0]  MODE_BASE     = 4'h8;
endpackage

// ===== src/tcs_clock_select.sv
// Count clock selection for six timer channels with external pin edge detection
`timescale 1ns/1ps

// Operation
// - Codes 000-011 pick system clock divided by 1, 4, 16, 64 on every channel.
// - Every prescaler field resets to 000, undivided system clock.
// - Channel 0 codes 100-111 select pins A, B, C, D.
// - Channel 1: 100 pin A, 101 pin B, 110 clock/256, 111 channel 2 overflow/underflow.
// - Channel 2: 100 pin A, 101 pin B, 110 pin C, 111 clock/1024.
// - Channel 3: 100 pin A, 101 clock/1024, 110 clock/256, 111 clock/4096.
// - Channel 4: 100 pin A, 101 pin C, 110 clock/1024, 111 channel 5 overflow/underflow.
// - Channel 5: 100 pin A, 101 pin C, 110 clock/256, 111 pin D.
// - Channel 1 in phase counting ignores its prescaler selection.
// - Channel 2 in phase counting ignores its prescaler selection.
// - Channel 4 in phase counting ignores its prescaler selection.
// - Channel 5 in phase counting ignores its prescaler selection.
// - Two-bit edge field picks rising, falling or both edges of a selected divider tap or pin.
module tcs_clock_select
  import tcs_pkg::*;
#(
  parameter int unsigned NCHAN = NUM_CHAN
) (
  input  wire logic              sys_clk_i,        // System clock, 10 MHz
  input  wire logic              rst_i,            // Asynchronous reset, active high
  input  wire logic [ADDR_W-1:0] addr_i,           // Register address
  input  wire logic [DATA_W-1:0] wdata_i,          // Write data
  input  wire logic              wr_i,             // Write strobe
  input  wire logic              rd_i,             // Read strobe
  output logic      [DATA_W-1:0] rdata_o,          // Read data, cycle after strobe
  input  wire logic              ext_clk_pin_a_i,  // External clock pin A
  input  wire logic              ext_clk_pin_b_i,  // External clock pin B
  input  wire logic              ext_clk_pin_c_i,  // External clock pin C
  input  wire logic              ext_clk_pin_d_i,  // External clock pin D
  input  wire logic              chan2_ovf_i,      // Channel 2 counter over/underflow pulse
  input  wire logic              chan5_ovf_i,      // Channel 5 counter over/underflow pulse
  output logic      [NCHAN-1:0]  count_en_o,       // Per-channel count enable pulse
  output logic      [NCHAN-1:0]  phase_mode_o      // Per-channel phase counting active
);

  // The source table is fixed per channel, so only six channels can be served
  if (NCHAN != NUM_CHAN) begin : g_bad_nchan
    $error("tcs_clock_select serves exactly six channels");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [DATA_W-1:0] ctrl_reg [NCHAN];
  logic [DATA_W-1:0] mode_reg [NCHAN];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCHAN; i++) begin
        ctrl_reg[i] <= CTRL_RESET;
      end
    end else if (wr_i) begin
      for (int i = 0; i < NCHAN; i++) begin
        if (addr_i == CTRL_BASE + ADDR_W'(i)) begin
          ctrl_reg[i] <= wdata_i & CTRL_WR_MASK;
        end
      end
    end
  end

  // Phase counting exists only on channels 1, 2, 4 and 5; others keep mode bit 2 at zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCHAN; i++) begin
        mode_reg[i] <= MODE_RESET;
      end
    end else if (wr_i) begin
      for (int i = 0; i < NCHAN; i++) begin
        if (addr_i == MODE_BASE + ADDR_W'(i)) begin
          if (i == 0 || i == 3) begin
            mode_reg[i] <= wdata_i & MODE_WR_MASK & ~(DATA_W'(1) << PHASE_BIT);
          end else begin
            mode_reg[i] <= wdata_i & MODE_WR_MASK;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= 8'h00;
      for (int i = 0; i < NCHAN; i++) begin
        if (addr_i == CTRL_BASE + ADDR_W'(i)) begin
          rdata_o <= ctrl_reg[i];
        end
        if (addr_i == MODE_BASE + ADDR_W'(i)) begin
          rdata_o <= mode_reg[i];
        end
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------
  // Prescaler and external pin edges
  // ----------------------------------------
  logic [DIV_W-1:0] presc_reg;
  logic [DIV_W-1:0] presc_next;
  always_comb presc_next = presc_reg + DIV_W'(1);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_next;
    end
  end

  // Divided clock is the prescaler bit as a level; edge logic sees both its edges
  function automatic logic tap(input logic [DIV_W-1:0] p, input int unsigned b);
    tap = p[b];
  endfunction

  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {ext_clk_pin_d_i, ext_clk_pin_c_i, ext_clk_pin_b_i, ext_clk_pin_a_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic [3:0] pins;
  assign pins = pin_sync_reg;

  // ----------------------------------------
  // Per-channel source selection
  // ----------------------------------------
  // Each channel yields a level (divided clock or pin), a ready-made event pulse, or the undivided-clock flag.
  logic [NCHAN-1:0] src_level;
  logic [NCHAN-1:0] src_is_evt;
  logic [NCHAN-1:0] src_evt;
  logic [NCHAN-1:0] src_undiv;
  logic [NCHAN-1:0] phase_act;

  always_comb begin
    for (int i = 0; i < NCHAN; i++) begin
      logic [2:0] s;
      s = ctrl_reg[i][SEL_LSB +: SEL_W];
      src_level[i]  = 1'b0;
      src_is_evt[i] = 1'b0;
      src_evt[i]    = 1'b0;
      src_undiv[i]  = 1'b0;
      phase_act[i]  = mode_reg[i][PHASE_BIT];
      unique case (s)
        SEL_DIV1:  src_undiv[i] = 1'b1;
        SEL_DIV4:  src_level[i] = tap(presc_reg, TAP_DIV4);
        SEL_DIV16: src_level[i] = tap(presc_reg, TAP_DIV16);
        SEL_DIV64: src_level[i] = tap(presc_reg, TAP_DIV64);
        SEL_C4:    src_level[i] = pins[0];
        SEL_C5: begin
          unique case (i)
            0, 1, 2: src_level[i] = pins[1];
            3:       src_level[i] = tap(presc_reg, TAP_DIV1024);
            default: src_level[i] = pins[2];
          endcase
        end
        SEL_C6: begin
          unique case (i)
            0, 2:    src_level[i] = pins[2];
            1, 3, 5: src_level[i] = tap(presc_reg, TAP_DIV256);
            default: src_level[i] = tap(presc_reg, TAP_DIV1024);
          endcase
        end
        SEL_C7: begin
          unique case (i)
            0, 5:    src_level[i] = pins[3];
            1: begin
              src_is_evt[i] = 1'b1;
              src_evt[i]    = chan2_ovf_i;
            end
            2:       src_level[i] = tap(presc_reg, TAP_DIV1024);
            3:       src_level[i] = tap(presc_reg, TAP_DIV4096);
            default: begin
              src_is_evt[i] = 1'b1;
              src_evt[i]    = chan5_ovf_i;
            end
          endcase
        end
      endcase
    end
  end

  // ----------------------------------------
  // Edge qualification
  // ----------------------------------------
  logic [NCHAN-1:0] level_d_reg;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_d_reg <= '0;
    end else begin
      level_d_reg <= src_level;
    end
  end

  // Undivided clock and channel overflows count every event; edge field is ignored there
  logic [NCHAN-1:0] en_next;
  always_comb begin
    for (int i = 0; i < NCHAN; i++) begin
      logic rise;
      logic fall;
      logic [1:0] e;
      rise = src_level[i] & ~level_d_reg[i];
      fall = ~src_level[i] & level_d_reg[i];
      e    = ctrl_reg[i][EDGE_LSB +: EDGE_W];
      if (phase_act[i]) begin
        en_next[i] = 1'b0;
      end else if (src_undiv[i]) begin
        en_next[i] = 1'b1;
      end else if (src_is_evt[i]) begin
        en_next[i] = src_evt[i];
      end else if (e == EDGE_RISE) begin
        en_next[i] = rise;
      end else if (e == EDGE_FALL) begin
        en_next[i] = fall;
      end else begin
        en_next[i] = rise | fall;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_en_o   <= '0;
      phase_mode_o <= '0;
    end else begin
      count_en_o   <= en_next;
      phase_mode_o <= phase_act;
    end
  end

endmodule

// ===== verif/tcs_pin_model.sv
// Far-side stand-in: free-running external clock pins and channel wrap pulses
`timescale 1ns/1ps
module tcs_pin_model (
  input  wire logic sys_clk_i,       // System clock
  input  wire logic rst_i,           // Reset, active high
  output logic      ext_clk_pin_a_o, // Pin A, period 10
  output logic      ext_clk_pin_b_o, // Pin B, period 14
  output logic      ext_clk_pin_c_o, // Pin C, period 18
  output logic      ext_clk_pin_d_o, // Pin D, period 22
  output logic      chan2_ovf_o,     // Channel 2 wrap, every 26
  output logic      chan5_ovf_o      // Channel 5 wrap, every 34
);
  int unsigned cnt_reg;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) cnt_reg <= 0;
    else cnt_reg <= cnt_reg + 1;
  end
  // Distinct periods, so a wrong source shows as a wrong spacing
  assign ext_clk_pin_a_o = (cnt_reg % 10) < 5;
  assign ext_clk_pin_b_o = (cnt_reg % 14) < 7;
  assign ext_clk_pin_c_o = (cnt_reg % 18) < 9;
  assign ext_clk_pin_d_o = (cnt_reg % 22) < 11;
  assign chan2_ovf_o = (cnt_reg % 26) == 25;
  assign chan5_ovf_o = (cnt_reg % 34) == 33;
endmodule

// ===== verif/tcs_clock_select_assertions.sv
// Port assertions for the count clock selector
`timescale 1ns/1ps
module tcs_clock_select_assertions
  import tcs_pkg::*;
#(parameter int unsigned NCHAN = NUM_CHAN) (
  input wire logic              sys_clk_i,       // Clock
  input wire logic              rst_i,           // Reset
  input wire logic [ADDR_W-1:0] addr_i,          // Address
  input wire logic [DATA_W-1:0] wdata_i,         // Write data
  input wire logic              wr_i,            // Write strobe
  input wire logic              ext_clk_pin_a_i, // Pin A
  input wire logic              ext_clk_pin_d_i, // Pin D
  input wire logic              chan2_ovf_i,     // Channel 2 wrap
  input wire logic              chan5_ovf_i,     // Channel 5 wrap
  input wire logic [NCHAN-1:0]  count_en_o,      // Enables
  input wire logic [NCHAN-1:0]  phase_mode_o     // Phase flags
);
  logic [4:0]       ctl_reg [NCHAN];
  logic [NCHAN-1:0] ph_reg;
  logic [3:0]       quiet_reg;
  wire              quiet = quiet_reg[3];
  // Shadow settings; checks wait 8 quiet cycles so the pin synchronisers drain
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg <= '{default: '0};
      ph_reg <= '0;
      quiet_reg <= '0;
    end else if (wr_i) begin
      quiet_reg <= '0;
      if (addr_i < NCHAN) ctl_reg[addr_i] <= wdata_i[4:0];
      else if (addr_i >= MODE_BASE && addr_i < MODE_BASE + NCHAN)
        ph_reg[addr_i - MODE_BASE] <= wdata_i[PHASE_BIT];
    end else if (!quiet) quiet_reg <= quiet_reg + 4'h1;
  end
  default clocking @(posedge sys_clk_i); endclocking
  // A write in flight abandons open attempts: the selection is being changed
  default disable iff (rst_i || wr_i);
  sequence gap3_s;
    !count_en_o[0] [*3] ##1 count_en_o[0];
  endsequence
  sequence pin_lat_s;
    ##[2:5] count_en_o[0];
  endsequence
  div1_every_a:
    assert property (quiet && ctl_reg[0] == 5'h00 |-> count_en_o[0]) else $error("div1 gap");
  div4_gap_a:
    assert property (quiet && ctl_reg[0] == 5'h01 && count_en_o[0] |=> gap3_s)
      else $error("div4 spacing wrong");
  pin_a_hit_a:
    assert property (quiet && ctl_reg[0] == 5'h04 && $rose(ext_clk_pin_a_i) |-> pin_lat_s)
      else $error("pin A edge not counted");
  wrap_two_a:
    assert property (quiet && ctl_reg[1] == 5'h07 && !ph_reg[1] && chan2_ovf_i |=> count_en_o[1])
      else $error("channel 2 wrap not counted");
  wrap_five_a:
    assert property (quiet && ctl_reg[4] == 5'h07 && !ph_reg[4] && chan5_ovf_i |=> count_en_o[4])
      else $error("channel 5 wrap not counted");
  pin_d_hit_a:
    assert property (quiet && ctl_reg[5] == 5'h07 && !ph_reg[5] && $rose(ext_clk_pin_d_i)
      |-> ##[2:5] count_en_o[5]) else $error("pin D edge not counted");
  phase_one_a:
    assert property (quiet && ph_reg[1] |-> !count_en_o[1] && phase_mode_o[1]) else $error("ch1");
  phase_two_a:
    assert property (quiet && ph_reg[2] |-> !count_en_o[2] && phase_mode_o[2]) else $error("ch2");
  phase_four_a:
    assert property (quiet && ph_reg[4] |-> !count_en_o[4] && phase_mode_o[4]) else $error("ch4");
  phase_five_a:
    assert property (quiet && ph_reg[5] |-> !count_en_o[5] && phase_mode_o[5]) else $error("ch5");
endmodule
bind tcs_clock_select tcs_clock_select_assertions #(.NCHAN(NCHAN)) chk_i (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .ext_clk_pin_a_i(ext_clk_pin_a_i), .ext_clk_pin_d_i(ext_clk_pin_d_i),
  .chan2_ovf_i(chan2_ovf_i), .chan5_ovf_i(chan5_ovf_i),
  .count_en_o(count_en_o), .phase_mode_o(phase_mode_o));

// ===== verif/tb.sv
// Self-checking bench for the count clock selector
`timescale 1ns/1ps
module tb;
  import tcs_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, d;
  logic        pa, pb, pc, pd, o2, o5;
  logic [5:0]  cen, pm;
  logic [31:0] seed = 32'h9c3d63f2;
  int          err_count = 0;
  int          checks = 0;
  int          p;
  string       nm;
  // Spacing for codes 100-111 per channel, given the model's pin and wrap periods
  localparam int PT [6][4] = '{'{10, 14, 18, 22}, '{10, 14, 256, 26}, '{10, 14, 18, 1024},
    '{10, 1024, 256, 4096}, '{10, 18, 1024, 34}, '{10, 18, 256, 22}};
  always #50 sys_clk = ~sys_clk;
  tcs_clock_select tcs_clock_select_i (.sys_clk_i(sys_clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_clk_pin_a_i(pa),
    .ext_clk_pin_b_i(pb), .ext_clk_pin_c_i(pc), .ext_clk_pin_d_i(pd), .chan2_ovf_i(o2),
    .chan5_ovf_i(o5), .count_en_o(cen), .phase_mode_o(pm));
  tcs_pin_model tcs_pin_model_i (.sys_clk_i(sys_clk), .rst_i(rst), .ext_clk_pin_a_o(pa),
    .ext_clk_pin_b_o(pb), .ext_clk_pin_c_o(pc), .ext_clk_pin_d_o(pd), .chan2_ovf_o(o2),
    .chan5_ovf_o(o5));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic int exp_p(input int c, input int code);
    if (code < 4) return 1 << (2 * code);
    return PT[c][code - 4];
  endfunction
  function automatic logic [7:0] exp_rd(input logic [3:0] a, input logic [7:0] v);
    if (a < 4'h6) return v & 8'h1f;
    if (a < 4'h8 || a > 4'hd) return 8'h00;
    if (a == 4'h8 || a == 4'hb) return v & 8'h03;
    return v & 8'h07;
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    v = rdata;
  endtask
  // Cycles between two enables; the first one may belong to the old setting
  task automatic period(input int ch, output int n);
    int k = 0;
    do begin @(posedge sys_clk); k++; end while (cen[ch] !== 1'b1 && k < 9000);
    n = 0;
    do begin @(posedge sys_clk); n++; end while (cen[ch] !== 1'b1 && n < 9000);
  endtask
  task automatic close_out();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int c = 0; c < 6; c++) begin
      rd_reg(4'(c), d);
      chk("ctrl reset", d, 8'h00);
      period(c, p);
      chk("reset spacing", p, 1);
    end
    $display("test reset done");
    for (int code = 0; code < 8; code++) begin
      for (int c = 0; c < 6; c++) wr_reg(4'(c), 8'(code));
      repeat (8) @(posedge sys_clk);
      for (int c = 0; c < 6; c++) begin
        period(c, p);
        nm = $sformatf("spacing ch%0d code%0d", c, code);
        chk(nm, p, exp_p(c, code));
      end
      $display("test code %0d done", code);
    end
    for (int e = 0; e < 4; e++) begin
      wr_reg(4'h3, 8'(e * 8 + 1));
      repeat (8) @(posedge sys_clk);
      period(3, p);
      chk("edge spacing", p, e < 2 ? 4 : 2);
    end
    $display("test edge done");
    for (int c = 0; c < 6; c++) wr_reg(MODE_BASE + 4'(c), 8'h04);
    // The enable launched at the last write's edge still reflects the old mode
    repeat (2) @(posedge sys_clk);
    d = 8'h00;
    repeat (64) begin
      @(posedge sys_clk);
      d = d | {2'b00, cen & 6'b110110};
    end
    chk("blocked enables", d, 8'h00);
    chk("phase flags", {2'b00, pm}, 8'h36);
    for (int c = 0; c < 6; c++) wr_reg(MODE_BASE + 4'(c), 8'h00);
    period(1, p);
    chk("phase released", p, 26);
    $display("test phase done");
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      wr_reg(seed[3:0], seed[15:8]);
      rd_reg(seed[3:0], d);
      chk("reg readback", d, exp_rd(seed[3:0], seed[15:8]));
    end
    $display("test random done");
    close_out();
  end
endmodule
